// file: pkg/irq_ctrl_params.svh
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFF_VECTOR 8'h00
`define OFF_SW_BASE 8'h04
`define OFF_PENDING 8'h08
`define OFF_IN_SERVICE 8'h0C
`define OFF_MASK 8'h10
`define OFF_CASCADE 8'h14
`define OFF_MODE 8'h18
`define OFF_ACK 8'h1C
`define OFF_RETURN 8'h20
`define OFF_TRIGGER 8'h24

// ----------------------------------------
// mode control fields
// ----------------------------------------
`define MODE_FREEZE_BIT 0
`define MODE_ROTATE_DIS_BIT 1
`define MODE_ENABLE_BIT 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_MASK 16'hFFFF
`define RST_SW_BASE 8'h00
`define RST_MODE 8'h00
`define RST_VECTOR 8'h00

// ----------------------------------------
// widths and counts
// ----------------------------------------
`define NUM_POS 16
`define POS_W 4
`define CNT_W 4

`endif

// file: pkg/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  // bus slave phases
  typedef enum logic [1:0] {
    bus_idle,
    bus_answer
  } bus_state_e;

  // result of the priority search
  typedef struct packed {
    logic found;
    logic [3:0] pos;
  } pick_s;
endpackage

// file: pkg/irq_pick_if.sv
`timescale 1ns/100ps
// request set and search result between the top and the priority picker
interface irq_pick_if;
  logic [15:0] request;
  logic [15:0] blocking;
  logic [3:0] first_pos;
  irq_ctrl_pkg::pick_s winner;
  modport top(output request, output blocking, output first_pos, input winner);
  modport picker(input request, input blocking, input first_pos, output winner);
endinterface

// file: core/irq_priority_pick.sv
`timescale 1ns/100ps
`include "irq_ctrl_params.svh"
// ----------------------------------------
// rotating priority search
// ----------------------------------------
module irq_priority_pick (
  // search port
  irq_pick_if.picker pick
);
  // first position in rank order holding a request, at or before the first blocker
  always_comb begin
    logic stop;
    logic [3:0] idx;
    stop = 1'b0;
    idx = 4'h0;
    pick.winner = '0;
    for (int i = 0; i < `NUM_POS; i++) begin
      idx = 4'(pick.first_pos + 4'(i));
      if (!stop) begin
        if (pick.request[idx]) begin
          pick.winner.found = 1'b1;
          pick.winner.pos = idx;
          stop = 1'b1;
        end else if (pick.blocking[idx]) begin
          stop = 1'b1;
        end
      end
    end
  end
endmodule

// file: core/irq_hw_sense.sv
`timescale 1ns/100ps
`include "irq_ctrl_params.svh"
// ----------------------------------------
// hardware request sensing
// ----------------------------------------
module irq_hw_sense #(
  parameter int N = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // sources
  input wire logic [N-1:0] ext_request,
  input wire logic [N-1:0] counter_request,
  input wire logic [N-1:0] counter_select,
  input wire logic [N-1:0] edge_mode,
  // sensed requests, forced to zero while freezing
  input wire logic freeze_pending,
  input wire logic [N-1:0] taken,
  output logic [N-1:0] hw_set
);
  typedef struct packed {
    logic [N-1:0] prev;
    logic [N-1:0] latched;
  } sense_s;
  sense_s cur;
  sense_s next_cur;
  logic [N-1:0] src;

  // counter or pin per position, edges latched until delivered
  always_comb begin
    src = (counter_select & counter_request) | (~counter_select & ext_request);
    next_cur = cur;
    next_cur.prev = src;
    next_cur.latched = (cur.latched & ~taken) | (edge_mode & src & ~cur.prev);
    hw_set = freeze_pending ? '0 : ((edge_mode & cur.latched) | (~edge_mode & src));
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

// file: core/irq_controller.sv
`timescale 1ns/100ps
`include "irq_ctrl_params.svh"
// Notes on behaviour
// - reset pin high clears control state; controller idle until software enables it
// - unmasked active request raises interrupt output and prepares a vector
// - interrupt output is active low
// - low four vector bits carry the acknowledged position number
// - return cycle ends service and pending requests re-arbitrate
// - cascaded position answers acknowledge with a negative cascade index
// - up to sixteen slaves may feed request inputs, 256 sources
// - each position keeps a hidden 4-bit in-service counter
// - slave supplies the final unsigned vector on cascaded acknowledge
// - master return cycle for cascaded position gives the same negative index
// - host ignores slave byte during cascaded return cycle
// - pending register writes set or clear software interrupts bit by bit
// - mask bit blocks a position from raising the output
// - freeze bit stops hardware requests setting pending bits
// - internal requests from counter outputs, external from request pins
// - output only for unmasked request at or above every in-service priority, fixed mode cascaded ones aside
// - acknowledge clears winner pending bit and sets its in-service bit
// - fixed mode cascaded acknowledge increments in-service counter
// - in-service bit stays until return and counter reaches zero
// - set in-service bit holds output off unless same or higher request appears, or the bit is fixed mode cascaded
// - fixed mode cascaded in-service bit does not block same priority
// - rotate-disable set selects fixed mode; reset enters auto-rotate
// - default rank puts position zero highest, fifteen lowest
module irq_controller #(
  parameter int N = `NUM_POS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // hardware request sources
  input wire logic [N-1:0] ext_request,
  input wire logic [N-1:0] counter_request,
  // interrupt to host
  output logic irq_n
);
  typedef struct packed {
    irq_ctrl_pkg::bus_state_e bus;
    logic [31:0] rdata;
    logic [N-1:0] pending_bits;
    logic [N-1:0] in_service_bits;
    logic [N-1:0] position_mask_bits;
    logic [N-1:0] cascaded_position_list;
    logic [N-1:0] counter_select;
    logic [N-1:0] edge_mode;
    logic [7:0] software_vector_base;
    logic [7:0] mode_control_reg;
    logic [3:0] first_pos;
    logic [3:0] last_ack;
    logic [N-1:0][`CNT_W-1:0] svc_count;
    logic irq;
  } ctrl_s;

  ctrl_s cur;
  ctrl_s next_cur;
  irq_pick_if pick_bus ();
  logic [N-1:0] hw_set;
  logic [N-1:0] ack_taken;
  logic fixed_mode;
  logic hit;
  logic [7:0] ack_vec;
  logic [3:0] ret_pos;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) res[7:0] = wd[7:0];
    if (be[1]) res[15:8] = wd[15:8];
    return res;
  endfunction

  // vector byte for a position
  function automatic logic [7:0] vector_of(input logic [3:0] pos, input logic casc,
                                           input logic [7:0] base);
    if (casc) begin
      return 8'(~{4'h0, pos}); // negative index -1-pos
    end
    return {base[7:4], pos};
  endfunction

  // ----------------------------------------
  // sub blocks
  // ----------------------------------------
  irq_hw_sense #(.N(N)) u_sense (
    .core_clk(core_clk),
    .rst(rst),
    .ext_request(ext_request),
    .counter_request(counter_request),
    .counter_select(cur.counter_select),
    .edge_mode(cur.edge_mode),
    .freeze_pending(cur.mode_control_reg[`MODE_FREEZE_BIT]),
    .taken(ack_taken),
    .hw_set(hw_set)
  );

  irq_priority_pick u_pick (
    .pick(pick_bus.picker)
  );

  // ----------------------------------------
  // arbitration inputs
  // ----------------------------------------
  always_comb begin
    fixed_mode = cur.mode_control_reg[`MODE_ROTATE_DIS_BIT];
    pick_bus.request = cur.pending_bits & ~cur.position_mask_bits;
    pick_bus.blocking = cur.in_service_bits;
    if (fixed_mode) begin
      pick_bus.blocking = cur.in_service_bits & ~cur.cascaded_position_list;
    end
    pick_bus.first_pos = cur.first_pos;
    hit = pick_bus.winner.found && cur.mode_control_reg[`MODE_ENABLE_BIT];
    ack_vec = vector_of(pick_bus.winner.pos, cur.cascaded_position_list[pick_bus.winner.pos],
                        cur.software_vector_base);
    ret_pos = cur.last_ack;
    // return clears highest ranked in-service position
    for (int i = N - 1; i >= 0; i--) begin
      if (cur.in_service_bits[4'(cur.first_pos + 4'(i))]) begin
        ret_pos = 4'(cur.first_pos + 4'(i));
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] sw_val;
    logic acc;
    logic is_ack;
    logic is_ret;
    sw_val = '0;
    acc = (avs_read || avs_write) && cur.bus == irq_ctrl_pkg::bus_idle;
    is_ack = acc && avs_read && avs_address == `OFF_ACK;
    is_ret = acc && avs_read && avs_address == `OFF_RETURN;
    next_cur = cur;
    ack_taken = '0;
    next_cur.irq = hit;
    next_cur.bus = acc ? irq_ctrl_pkg::bus_answer : irq_ctrl_pkg::bus_idle;
    next_cur.rdata = '0;
    next_cur.pending_bits = cur.pending_bits | hw_set;
    // register reads
    if (acc && avs_read) begin
      if (avs_address == `OFF_VECTOR) begin
        next_cur.rdata = {24'h0, ack_vec};
      end else if (avs_address == `OFF_SW_BASE) begin
        next_cur.rdata = {24'h0, cur.software_vector_base};
      end else if (avs_address == `OFF_PENDING) begin
        next_cur.rdata = {16'h0, cur.pending_bits};
      end else if (avs_address == `OFF_IN_SERVICE) begin
        next_cur.rdata = {16'h0, cur.in_service_bits};
      end else if (avs_address == `OFF_MASK) begin
        next_cur.rdata = {16'h0, cur.position_mask_bits};
      end else if (avs_address == `OFF_CASCADE) begin
        next_cur.rdata = {16'h0, cur.cascaded_position_list};
      end else if (avs_address == `OFF_MODE) begin
        next_cur.rdata = {20'h0, cur.first_pos, 5'h0, cur.mode_control_reg[2:0]};
      end else if (avs_address == `OFF_TRIGGER) begin
        next_cur.rdata = {cur.edge_mode, cur.counter_select};
      end
    end
    // acknowledge cycle
    if (is_ack) begin
      if (hit) begin
        next_cur.rdata = {24'h0, ack_vec};
        ack_taken[pick_bus.winner.pos] = 1'b1;
        next_cur.pending_bits[pick_bus.winner.pos] = 1'b0;
        next_cur.in_service_bits[pick_bus.winner.pos] = 1'b1;
        next_cur.last_ack = pick_bus.winner.pos;
        if (fixed_mode && cur.cascaded_position_list[pick_bus.winner.pos]) begin
          next_cur.svc_count[pick_bus.winner.pos] =
            4'(cur.svc_count[pick_bus.winner.pos] + 4'h1);
        end
        next_cur.irq = 1'b0;
      end else begin
        next_cur.rdata = {24'h0, cur.software_vector_base};
      end
    end
    // return cycle
    if (is_ret && cur.in_service_bits != '0) begin
      next_cur.rdata = {24'h0, vector_of(ret_pos, cur.cascaded_position_list[ret_pos],
                                         cur.software_vector_base)};
      if (cur.svc_count[ret_pos] > 4'h1) begin
        next_cur.svc_count[ret_pos] = 4'(cur.svc_count[ret_pos] - 4'h1);
      end else begin
        next_cur.svc_count[ret_pos] = 4'h0;
        next_cur.in_service_bits[ret_pos] = 1'b0;
        if (!fixed_mode) begin
          next_cur.first_pos = 4'(ret_pos + 4'h1); // rotate
        end
      end
    end
    // register writes land at the edge where waitrequest is seen low
    if (avs_write && cur.bus == irq_ctrl_pkg::bus_answer) begin
      if (avs_address == `OFF_SW_BASE && avs_byteenable[0]) begin
        next_cur.software_vector_base = avs_writedata[7:0];
      end else if (avs_address == `OFF_PENDING) begin
        sw_val = merge16(cur.pending_bits, avs_writedata, avs_byteenable);
        next_cur.pending_bits = sw_val | hw_set; // set wins
      end else if (avs_address == `OFF_IN_SERVICE) begin
        next_cur.in_service_bits = merge16(cur.in_service_bits, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFF_MASK) begin
        next_cur.position_mask_bits =
          merge16(cur.position_mask_bits, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFF_CASCADE) begin
        next_cur.cascaded_position_list =
          merge16(cur.cascaded_position_list, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFF_MODE) begin
        if (avs_byteenable[0]) begin
          next_cur.mode_control_reg = {5'h0, avs_writedata[2:0]};
        end
        if (avs_byteenable[1]) begin
          next_cur.first_pos = avs_writedata[11:8];
        end
      end else if (avs_address == `OFF_TRIGGER) begin
        if (avs_byteenable[1:0] == 2'b11) begin
          next_cur.counter_select = avs_writedata[15:0];
        end
        if (avs_byteenable[3:2] == 2'b11) begin
          next_cur.edge_mode = avs_writedata[31:16];
        end
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.position_mask_bits <= `RST_MASK;
      cur.software_vector_base <= `RST_SW_BASE;
      cur.mode_control_reg <= `RST_MODE; // auto-rotate
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_readdata = cur.rdata;
  assign avs_waitrequest = cur.bus == irq_ctrl_pkg::bus_idle; // answer one cycle after
  assign irq_n = ~cur.irq;
endmodule

// file: tb/irq_controller_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checker for the interrupt controller
// ----------------------------------------
module irq_controller_monitor #(
  parameter int N = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // sources and interrupt
  input wire logic [N-1:0] ext_request,
  input wire logic [N-1:0] counter_request,
  input wire logic irq_n
);
  logic done;
  logic armed;
  logic [2:0] age;
  assign done = (avs_read | avs_write) & ~avs_waitrequest;
  // enable seen, and cycles since anything could raise a request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
      age <= 3'h7;
    end else begin
      if (done & avs_write & avs_address == 8'h18 & avs_writedata[2]) armed <= 1'b1;
      if ((|ext_request) | (|counter_request) | (done & avs_address != 8'h1C)) age <= 3'h0;
      else if (age != 3'h7) age <= age + 3'h1;
    end
  end
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence take_s;
    (avs_read | avs_write) & avs_waitrequest;
  endsequence
  sequence ack_s;
    avs_read & ~avs_waitrequest & avs_address == 8'h1C;
  endsequence
  reset_quiet_a: assert property ($fell(rst) |-> irq_n) else $error("irq after reset");
  unconfig_quiet_a: assert property (!armed |-> irq_n) else $error("irq while disabled");
  answer_next_a: assert property (take_s |=> !avs_waitrequest) else $error("late answer");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  answer_caused_a: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
    else $error("answer without request");
  unmapped_zero_a: assert property (avs_read & ~avs_waitrequest & avs_address > 8'h24
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  ack_drops_irq_a: assert property (ack_s |=> irq_n) else $error("irq held after ack");
  irq_cause_a: assert property ($fell(irq_n) |-> age < 3'h4) else $error("irq without cause");
endmodule
bind irq_controller irq_controller_monitor #(.N(N)) irq_controller_monitor_inst (.core_clk, .rst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .ext_request, .counter_request, .irq_n);

// file: tb/slave_icu_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// cascaded slave controller on a master input
// ----------------------------------------
module slave_icu_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // host cycles at the slave
  input wire logic fire,
  input wire logic [7:0] fire_vec,
  input wire logic slave_ack,
  input wire logic slave_ret,
  // towards host and master
  output logic [7:0] slave_vec,
  output logic req
);
  // request held until the host acknowledges at the slave
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req <= 1'b0;
      slave_vec <= 8'h00;
    end else begin
      if (fire) req <= 1'b1;
      if (fire) slave_vec <= fire_vec;
      if (slave_ack) req <= 1'b0;
      if (slave_ret) slave_vec <= ~slave_vec;
    end
  end
endmodule

// file: tb/vectored_cascadable_irq_controller_tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------
// testbench top
// ----------------------------------------
module vectored_cascadable_irq_controller_tb_top;
  localparam logic [31:0] V = 32'hFF;
  localparam logic [31:0] H = 32'hFFFF;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, irq_n, fire, sack, sret, sreq;
  logic [7:0] avs_address, fvec, svec, base;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [15:0] ext_req, ext_request, counter_request;
  int n_fail, num_checks, p;
  // slave request lands on position 4
  assign ext_request = ext_req | {11'h0, sreq, 4'h0};
  irq_controller #(.N(16)) irq_controller_inst (.core_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .ext_request, .counter_request, .irq_n);
  slave_icu_model slave_icu_model_inst (.core_clk, .rst, .fire, .fire_vec(fvec),
    .slave_ack(sack), .slave_ret(sret), .slave_vec(svec), .req(sreq));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // expected vectors
  function automatic logic [31:0] vec(input logic [7:0] b, input int q);
    return {24'h0, b[7:4], 4'(q)};
  endfunction
  function automatic logic [31:0] casc(input int q);
    return {24'h0, 8'hFF - 8'(q)};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    k = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    q = avs_readdata;
    if (k >= 40) chk(32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic wirq(input logic lvl);
    int k;
    for (k = 0; k < 10 && irq_n !== lvl; k++) @(posedge core_clk);
    chk(32'(irq_n), 32'(lvl));
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("CHECK FAILED %0t watchdog", $time);
    results();
  end
  // main sequence
  initial begin
    n_fail = 0;
    num_checks = 0;
    rst = 1'b1;
    {avs_read, avs_write, fire, sack, sret} = '0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    {ext_req, counter_request} = '0;
    fvec = 8'h00;
    p = $urandom(98);
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdc(8'h10, 32'hFFFF, H);
    rdc(8'h18, 32'h0, H);
    rdc(8'h3C, 32'h0, 32'hFFFFFFFF);
    chk(32'(irq_n), 32'h1);
    base = {1'b0, 7'($urandom)};
    wr(8'h04, {24'h0, base});
    wr(8'h18, 32'h6);
    // every position as a software interrupt
    for (p = 0; p < 16; p++) begin
      wr(8'h10, ~(32'h1 << p));
      wr(8'h08, 32'h1 << p);
      wirq(1'b0);
      rdc(8'h1C, vec(base, p), V);
      rdc(8'h08, 32'h0, H);
      rdc(8'h0C, 32'h1 << p, H);
      chk(32'(irq_n), 32'h1);
      rdc(8'h20, vec(base, p), V);
      rdc(8'h0C, 32'h0, H);
    end
    // rank and blocking, bit 3 stays masked
    wr(8'h10, 32'hFDDF);
    wr(8'h08, 32'h0228);
    wirq(1'b0);
    rdc(8'h1C, vec(base, 5), V);
    repeat (4) @(posedge core_clk);
    chk(32'(irq_n), 32'h1);
    rdc(8'h20, vec(base, 5), V);
    wirq(1'b0);
    rdc(8'h1C, vec(base, 9), V);
    rdc(8'h20, vec(base, 9), V);
    repeat (4) @(posedge core_clk);
    chk(32'(irq_n), 32'h1);
    wr(8'h08, 32'h0);
    rdc(8'h08, 32'h0, H);
    // freeze, then pin against counter source
    p = $urandom_range(15, 10);
    wr(8'h18, 32'h7);
    ext_req[p] <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(8'h08, 32'h0, H);
    wr(8'h18, 32'h6);
    rdc(8'h08, 32'h1 << p, H);
    ext_req[p] <= 1'b0;
    repeat (3) @(posedge core_clk);
    wr(8'h08, 32'h0);
    wr(8'h24, 32'h1 << p);
    ext_req[p] <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(8'h08, 32'h0, H);
    ext_req[p] <= 1'b0;
    counter_request[p] <= 1'b1;
    repeat (3) @(posedge core_clk);
    counter_request[p] <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdc(8'h08, 32'h1 << p, H);
    wr(8'h08, 32'h0);
    // cascaded slave on position 4, nested twice
    wr(8'h24, 32'h0010_0000);
    wr(8'h14, 32'h10);
    wr(8'h10, 32'hFFEF);
    for (p = 0; p < 2; p++) begin
      fire <= 1'b1;
      fvec <= 8'($urandom);
      @(posedge core_clk);
      fire <= 1'b0;
      wirq(1'b0);
      rdc(8'h1C, casc(4), V);
      repeat ($urandom_range(3, 0)) @(posedge core_clk);
      sack <= 1'b1;
      @(posedge core_clk);
      sack <= 1'b0;
      chk(32'(svec), 32'(fvec));
    end
    rdc(8'h0C, 32'h10, H);
    for (p = 0; p < 2; p++) begin
      rdc(8'h20, casc(4), V);
      sret <= 1'b1;
      @(posedge core_clk);
      sret <= 1'b0;
      rdc(8'h0C, (p == 0) ? 32'h10 : 32'h0, H);
    end
    results();
  end
endmodule
